// ---- pmbus_regs_pkg.sv ----
// Contract
// RULE1: overcurrent warning limit 10..40 A and below the overcurrent fault limit.
// RULE2: overtemp fault limit 25..140 C and above the overtemp warning limit.
// RULE3: overtemp warning limit 25..125 C and below the overtemp fault limit.
// RULE4: input overvoltage limit 48..90 V; the device trips on it.
// RULE5: overtemp response code fixed at 10, delay field fixed at zero.
// RULE6: overtemp retry 000 never restarts; 111 restarts continuously while fault lasts.
// RULE7: overtemp response resets to shutdown, retry 111, no delay.
// RULE8: input overvoltage response fixed read-only 11/000; output off while fault present.
// RULE9: after input overvoltage shutdown, restart normally once the condition clears.
// RULE10: power good on/off thresholds 8.1..13.2 V, on exceeds off by 1.6 V.
// RULE11: turn-on delay 10..500 ms, applied before the output starts.
// RULE12: rise time 15..500 ms, output ramps over the programmed time.
// RULE13: status word read-only summary with documented high and low byte bits.
// RULE14: status word fans, other, unknown, mfr and busy bits stay inactive.
// RULE15: output voltage status implements only bit 7; all bits host resettable.
// RULE16: output current status implements the overcurrent fault flag, host resettable.
// RULE17: input status implements the input overvoltage fault flag, host resettable.
// RULE18: temperature status: fault bit 7, warning bit 6, others inactive, resettable.
// RULE19: communication status: bad command 7, bad data 6, checksum 5, resettable.
// RULE20: overcurrent fault limit 20..60 A and above the warning limit.
// RULE21: rejected limit write keeps old value and flags invalid data.
package pmbus_regs_pkg;
  // command codes
  localparam logic [7:0] OFS_OC_FAULT = 8'h46;
  localparam logic [7:0] OFS_OC_WARN = 8'h4a;
  localparam logic [7:0] OFS_OT_FAULT = 8'h4f;
  localparam logic [7:0] OFS_OT_RESP = 8'h50;
  localparam logic [7:0] OFS_OT_WARN = 8'h51;
  localparam logic [7:0] OFS_VIN_OV = 8'h55;
  localparam logic [7:0] OFS_VIN_RESP = 8'h56;
  localparam logic [7:0] OFS_PG_ON = 8'h5e;
  localparam logic [7:0] OFS_PG_OFF = 8'h5f;
  localparam logic [7:0] OFS_TON_DLY = 8'h60;
  localparam logic [7:0] OFS_TURN_ON_RAMP_TIME = 8'h61;
  localparam logic [7:0] OFS_SWORD = 8'h79;
  localparam logic [7:0] OFS_ST_VOUT = 8'h7a;
  localparam logic [7:0] OFS_ST_IOUT = 8'h7b;
  localparam logic [7:0] OFS_ST_IN = 8'h7c;
  localparam logic [7:0] OFS_ST_TEMP = 8'h7d;
  localparam logic [7:0] OFS_ST_CML = 8'h7e;
  localparam logic [7:0] OFS_RD_VIN = 8'h88;
  localparam logic [7:0] OFS_RD_VOUT = 8'h8b;
  // limit bounds: amps, deg C, 0.1 V steps, ms
  localparam logic [15:0] OC_WARN_MIN = 16'h000a;
  localparam logic [15:0] OC_WARN_MAX = 16'h0028;
  localparam logic [15:0] OC_FAULT_MIN = 16'h0014;
  localparam logic [15:0] OC_FAULT_MAX = 16'h003c;
  localparam logic [15:0] OT_MIN = 16'h0019;
  localparam logic [15:0] OT_FAULT_MAX = 16'h008c;
  localparam logic [15:0] OT_WARN_MAX = 16'h007d;
  localparam logic [15:0] VIN_OV_MIN = 16'h01e0;
  localparam logic [15:0] VIN_OV_MAX = 16'h0384;
  localparam logic [15:0] PG_MIN = 16'h0051;
  localparam logic [15:0] PG_MAX = 16'h0084;
  localparam logic [16:0] PG_HYST = 17'h00010;
  localparam logic [15:0] TON_DLY_MIN = 16'h000a;
  localparam logic [15:0] TURN_ON_RAMP_TIME_MIN = 16'h000f;
  localparam logic [15:0] TON_MAX = 16'h01f4;
  // reset values
  localparam logic [15:0] OC_FAULT_RST = 16'h002d;
  localparam logic [15:0] OC_WARN_RST = 16'h001e;
  localparam logic [15:0] OT_FAULT_RST = 16'h007d;
  localparam logic [15:0] OT_WARN_RST = 16'h006e;
  localparam logic [15:0] VIN_OV_RST = 16'h0320;
  localparam logic [15:0] PG_ON_RST = 16'h006e;
  localparam logic [15:0] PG_OFF_RST = 16'h005a;
  localparam logic [15:0] TON_DLY_RST = 16'h000a;
  localparam logic [15:0] TURN_ON_RAMP_TIME_RST = 16'h000f;
  localparam logic [7:0] OT_RESP_RST = 8'hb8;
  localparam logic [7:0] VIN_RESP_VAL = 8'hc0;
  // response fields
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [2:0] RETRY_NEVER = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;
  localparam logic [2:0] DELAY_NONE = 3'h0;
  // implemented status bits
  localparam logic [7:0] VOUT_MASK = 8'h80;
  localparam logic [7:0] IOUT_MASK = 8'ha0;
  localparam logic [7:0] IN_MASK = 8'h90;
  localparam logic [7:0] TEMP_MASK = 8'hc0;
  localparam logic [7:0] CML_MASK = 8'he0;
  localparam int FLT_BIT = 7;
  localparam int WARN_BIT = 6;
  localparam int OC_WARN_BIT = 5;
  localparam int UV_BIT = 4;
  localparam int CML_CMD_BIT = 7;
  localparam int CML_DATA_BIT = 6;
  localparam int CML_PEC_BIT = 5;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // output sequencer
  typedef enum logic [4:0] {
    SEQ_OFF = 5'b00001,
    SEQ_DELAY = 5'b00010,
    SEQ_RAMP = 5'b00100,
    SEQ_ON = 5'b01000,
    SEQ_LATCH = 5'b10000
  } seq_t;
endpackage

// ---- pmbus_fault_regs.sv ----
module pmbus_fault_regs #(
  parameter int CYC_PER_MS = pmbus_regs_pkg::CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_pec_err,
  input wire logic on_cmd,
  input wire logic [15:0] vin_sample,
  input wire logic [15:0] vout_sample,
  input wire logic [15:0] iout_sample,
  input wire logic [15:0] temp_sample,
  input wire logic vout_ov_fault,
  input wire logic vin_uv_fault,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic output_en,
  output logic ramp_active,
  output logic power_good
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic in_range(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // set beats clear so no event is lost
  function automatic logic [7:0] sticky(
    input logic [7:0] q,
    input logic [7:0] set,
    input logic [7:0] clr,
    input logic [7:0] mask
  );
    sticky = ((q & ~clr) | set) & mask;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [15:0] oc_fault_q, oc_warn_q, ot_fault_q, ot_warn_q;
  logic [15:0] vin_ov_q, pg_on_q, pg_off_q, ton_dly_q, turn_on_ramp_time_q;
  logic [7:0] ot_resp_q;
  logic [7:0] st_vout_q, st_iout_q, st_in_q, st_temp_q, st_cml_q;
  logic [7:0] st_vout_d, st_iout_d, st_in_d, st_temp_d, st_cml_d;
  logic rsp_valid_q, en_q, pg_q, ramp_q;
  logic [15:0] rsp_data_q, rd_mux;
  logic [31:0] pre_q;
  logic [15:0] ms_q;
  pmbus_regs_pkg::seq_t seq_q, seq_d;

  // ************************************************************
  // command decode
  // ************************************************************
  wire [15:0] d = cmd_wdata;
  wire good = cmd_valid & ~cmd_pec_err;
  wire wr = good & cmd_write;
  wire rd = good & ~cmd_write;
  wire h_ocf = cmd_code == pmbus_regs_pkg::OFS_OC_FAULT;
  wire h_ocw = cmd_code == pmbus_regs_pkg::OFS_OC_WARN;
  wire h_otf = cmd_code == pmbus_regs_pkg::OFS_OT_FAULT;
  wire h_otr = cmd_code == pmbus_regs_pkg::OFS_OT_RESP;
  wire h_otw = cmd_code == pmbus_regs_pkg::OFS_OT_WARN;
  wire h_vov = cmd_code == pmbus_regs_pkg::OFS_VIN_OV;
  wire h_vor = cmd_code == pmbus_regs_pkg::OFS_VIN_RESP;
  wire h_pgn = cmd_code == pmbus_regs_pkg::OFS_PG_ON;
  wire h_pgf = cmd_code == pmbus_regs_pkg::OFS_PG_OFF;
  wire h_tdl = cmd_code == pmbus_regs_pkg::OFS_TON_DLY;
  wire h_trs = cmd_code == pmbus_regs_pkg::OFS_TURN_ON_RAMP_TIME;
  wire h_swd = cmd_code == pmbus_regs_pkg::OFS_SWORD;
  wire h_svo = cmd_code == pmbus_regs_pkg::OFS_ST_VOUT;
  wire h_sio = cmd_code == pmbus_regs_pkg::OFS_ST_IOUT;
  wire h_sin = cmd_code == pmbus_regs_pkg::OFS_ST_IN;
  wire h_stp = cmd_code == pmbus_regs_pkg::OFS_ST_TEMP;
  wire h_scm = cmd_code == pmbus_regs_pkg::OFS_ST_CML;
  wire h_rvi = cmd_code == pmbus_regs_pkg::OFS_RD_VIN;
  wire h_rvo = cmd_code == pmbus_regs_pkg::OFS_RD_VOUT;
  wire h_lim = h_ocf | h_ocw | h_otf | h_otr | h_otw | h_vov
             | h_pgn | h_pgf | h_tdl | h_trs;
  wire h_st = h_svo | h_sio | h_sin | h_stp | h_scm;
  wire h_ro = h_vor | h_swd | h_rvi | h_rvo;
  wire known = h_lim | h_st | h_ro;

  // ************************************************************
  // range and cross checks on written limits
  // ************************************************************
  wire ok_ocw = in_range(d, pmbus_regs_pkg::OC_WARN_MIN, // RULE1
    pmbus_regs_pkg::OC_WARN_MAX) && (d < oc_fault_q);
  wire ok_ocf = in_range(d, pmbus_regs_pkg::OC_FAULT_MIN, // RULE20
    pmbus_regs_pkg::OC_FAULT_MAX) && (d > oc_warn_q);
  wire ok_otf = in_range(d, pmbus_regs_pkg::OT_MIN, // RULE2
    pmbus_regs_pkg::OT_FAULT_MAX) && (d > ot_warn_q);
  wire ok_otw = in_range(d, pmbus_regs_pkg::OT_MIN, // RULE3
    pmbus_regs_pkg::OT_WARN_MAX) && (d < ot_fault_q);
  wire ok_vov = in_range(d, pmbus_regs_pkg::VIN_OV_MIN, // RULE4
    pmbus_regs_pkg::VIN_OV_MAX);
  // on must clear off by the full hysteresis gap
  wire ok_pgn = in_range(d, pmbus_regs_pkg::PG_MIN, // RULE10
    pmbus_regs_pkg::PG_MAX)
    && ({1'b0, d} >= {1'b0, pg_off_q} + pmbus_regs_pkg::PG_HYST);
  wire ok_pgf = in_range(d, pmbus_regs_pkg::PG_MIN, // RULE10
    pmbus_regs_pkg::PG_MAX)
    && ({1'b0, d} + pmbus_regs_pkg::PG_HYST <= {1'b0, pg_on_q});
  wire ok_tdl = in_range(d, pmbus_regs_pkg::TON_DLY_MIN, // RULE11
    pmbus_regs_pkg::TON_MAX);
  wire ok_trs = in_range(d, pmbus_regs_pkg::TURN_ON_RAMP_TIME_MIN, // RULE12
    pmbus_regs_pkg::TON_MAX);
  // only shutdown, no delay and retry never/always are legal
  wire ok_otr = (d[15:8] == 8'h00)
    && (d[7:6] == pmbus_regs_pkg::RESP_SHUTDOWN) // RULE5
    && (d[2:0] == pmbus_regs_pkg::DELAY_NONE)
    && ((d[5:3] == pmbus_regs_pkg::RETRY_NEVER) // RULE6
     || (d[5:3] == pmbus_regs_pkg::RETRY_ALWAYS));
  wire lim_ok = (h_ocw & ok_ocw) | (h_ocf & ok_ocf) | (h_otf & ok_otf)
              | (h_otw & ok_otw) | (h_vov & ok_vov) | (h_pgn & ok_pgn)
              | (h_pgf & ok_pgf) | (h_tdl & ok_tdl) | (h_trs & ok_trs)
              | (h_otr & ok_otr);
  wire bad_data = wr & h_lim & ~lim_ok; // RULE21
  wire bad_cmd = good & (~known | (cmd_write & h_ro));
  wire bad_pec = cmd_valid & cmd_pec_err;
  wire take = wr & h_lim & lim_ok;

  // ************************************************************
  // limit registers
  // ************************************************************
  // a refused write leaves the old value in place
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oc_fault_q <= pmbus_regs_pkg::OC_FAULT_RST;
      oc_warn_q <= pmbus_regs_pkg::OC_WARN_RST;
      ot_fault_q <= pmbus_regs_pkg::OT_FAULT_RST;
      ot_warn_q <= pmbus_regs_pkg::OT_WARN_RST;
      vin_ov_q <= pmbus_regs_pkg::VIN_OV_RST;
      pg_on_q <= pmbus_regs_pkg::PG_ON_RST;
      pg_off_q <= pmbus_regs_pkg::PG_OFF_RST;
      ton_dly_q <= pmbus_regs_pkg::TON_DLY_RST;
      turn_on_ramp_time_q <= pmbus_regs_pkg::TURN_ON_RAMP_TIME_RST;
      ot_resp_q <= pmbus_regs_pkg::OT_RESP_RST; // RULE7
    end
    else if (take)
    begin
      if (h_ocf) oc_fault_q <= d; // RULE20
      if (h_ocw) oc_warn_q <= d; // RULE1
      if (h_otf) ot_fault_q <= d; // RULE2
      if (h_otw) ot_warn_q <= d; // RULE3
      if (h_vov) vin_ov_q <= d; // RULE4
      if (h_pgn) pg_on_q <= d;
      if (h_pgf) pg_off_q <= d;
      if (h_tdl) ton_dly_q <= d;
      if (h_trs) turn_on_ramp_time_q <= d;
      if (h_otr) ot_resp_q <= d[7:0]; // RULE5
    end
  end

  // ************************************************************
  // live fault conditions
  // ************************************************************
  wire ot_live = temp_sample > ot_fault_q;
  wire otw_live = temp_sample > ot_warn_q;
  wire vov_live = vin_sample > vin_ov_q; // RULE4
  wire oc_live = iout_sample > oc_fault_q;
  wire ocw_live = iout_sample > oc_warn_q;
  wire other_live = vov_live | oc_live | vout_ov_fault | vin_uv_fault;
  wire any_live = other_live | ot_live;
  wire ot_never = ot_resp_q[5:3] == pmbus_regs_pkg::RETRY_NEVER;

  // ************************************************************
  // status flags
  // ************************************************************
  // host writes ones to reset bits, a same-cycle event still lands
  wire [7:0] clr_b = d[7:0];
  assign st_vout_d = sticky(st_vout_q, {vout_ov_fault, 7'h00}, // RULE15
    (wr & h_svo) ? clr_b : 8'h00, pmbus_regs_pkg::VOUT_MASK);
  assign st_iout_d = sticky(st_iout_q, // RULE16
    {oc_live, 1'b0, ocw_live, 5'h00},
    (wr & h_sio) ? clr_b : 8'h00, pmbus_regs_pkg::IOUT_MASK);
  assign st_in_d = sticky(st_in_q, // RULE17
    {vov_live, 2'h0, vin_uv_fault, 4'h0},
    (wr & h_sin) ? clr_b : 8'h00, pmbus_regs_pkg::IN_MASK);
  assign st_temp_d = sticky(st_temp_q, {ot_live, otw_live, 6'h00}, // RULE18
    (wr & h_stp) ? clr_b : 8'h00, pmbus_regs_pkg::TEMP_MASK);
  assign st_cml_d = sticky(st_cml_q, // RULE19
    {bad_cmd, bad_data, bad_pec, 5'h00},
    (wr & h_scm) ? clr_b : 8'h00, pmbus_regs_pkg::CML_MASK);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_vout_q <= 8'h00;
      st_iout_q <= 8'h00;
      st_in_q <= 8'h00;
      st_temp_q <= 8'h00;
      st_cml_q <= 8'h00;
    end
    else
    begin
      st_vout_q <= st_vout_d;
      st_iout_q <= st_iout_d;
      st_in_q <= st_in_d;
      st_temp_q <= st_temp_d;
      st_cml_q <= st_cml_d;
    end
  end

  // ************************************************************
  // status word and read answer
  // ************************************************************
  // unsupported summary bits are tied inactive
  wire [15:0] sword = { // RULE13 RULE14
    |st_vout_q, |st_iout_q, |st_in_q, 1'b0, ~pg_q, 3'h0,
    1'b0, ~en_q, st_vout_q[pmbus_regs_pkg::FLT_BIT],
    st_iout_q[pmbus_regs_pkg::FLT_BIT],
    st_in_q[pmbus_regs_pkg::UV_BIT], |st_temp_q, |st_cml_q, 1'b0};

  always_comb
  begin
    unique case (1'b1)
      h_ocf: rd_mux = oc_fault_q;
      h_ocw: rd_mux = oc_warn_q;
      h_otf: rd_mux = ot_fault_q;
      h_otr: rd_mux = {8'h00, ot_resp_q};
      h_otw: rd_mux = ot_warn_q;
      h_vov: rd_mux = vin_ov_q;
      h_vor: rd_mux = {8'h00, pmbus_regs_pkg::VIN_RESP_VAL}; // RULE8
      h_pgn: rd_mux = pg_on_q;
      h_pgf: rd_mux = pg_off_q;
      h_tdl: rd_mux = ton_dly_q;
      h_trs: rd_mux = turn_on_ramp_time_q;
      h_swd: rd_mux = sword;
      h_svo: rd_mux = {8'h00, st_vout_q};
      h_sio: rd_mux = {8'h00, st_iout_q};
      h_sin: rd_mux = {8'h00, st_in_q};
      h_stp: rd_mux = {8'h00, st_temp_q};
      h_scm: rd_mux = {8'h00, st_cml_q};
      h_rvi: rd_mux = vin_sample;
      h_rvo: rd_mux = vout_sample;
      default: rd_mux = 16'h0000;
    endcase
  end

  // answer one cycle after the read is taken
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end
    else
    begin
      rsp_valid_q <= rd & known;
      rsp_data_q <= (rd & known) ? rd_mux : rsp_data_q;
    end
  end

  // ************************************************************
  // turn-on sequencer
  // ************************************************************
  // millisecond prescaler, restarted on every state change
  wire tick = pre_q == 32'(CYC_PER_MS - 1);
  wire ms_end_dly = tick && (ms_q == ton_dly_q - 16'h0001); // RULE11
  wire ms_end_rise = tick && (ms_q == turn_on_ramp_time_q - 16'h0001); // RULE12
  wire running = seq_q == pmbus_regs_pkg::SEQ_DELAY || seq_q == pmbus_regs_pkg::SEQ_RAMP
    || seq_q == pmbus_regs_pkg::SEQ_ON;

  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      // overtemp with retry always may start again at once
      pmbus_regs_pkg::SEQ_OFF:
        if (on_cmd && !other_live) seq_d = pmbus_regs_pkg::SEQ_DELAY; // RULE6 RULE9
      pmbus_regs_pkg::SEQ_DELAY:
        if (ms_end_dly) seq_d = pmbus_regs_pkg::SEQ_RAMP; // RULE11
      pmbus_regs_pkg::SEQ_RAMP:
        if (ms_end_rise) seq_d = pmbus_regs_pkg::SEQ_ON; // RULE12
      pmbus_regs_pkg::SEQ_ON:
        seq_d = seq_q;
      pmbus_regs_pkg::SEQ_LATCH:
        if (!on_cmd) seq_d = pmbus_regs_pkg::SEQ_OFF;
      default:
        seq_d = pmbus_regs_pkg::SEQ_OFF;
    endcase
    // shutdown has priority over any progress
    if (running && (!on_cmd || any_live))
    begin
      if (on_cmd && ot_live && ot_never)
        seq_d = pmbus_regs_pkg::SEQ_LATCH; // RULE6
      else
        seq_d = pmbus_regs_pkg::SEQ_OFF; // RULE8
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_q <= pmbus_regs_pkg::SEQ_OFF;
      pre_q <= 32'h0;
      ms_q <= 16'h0000;
    end
    else
    begin
      seq_q <= seq_d;
      pre_q <= (seq_d != seq_q || tick) ? 32'h0 : pre_q + 32'h1;
      ms_q <= (seq_d != seq_q) ? 16'h0000 : (tick ? ms_q + 16'h0001 : ms_q);
    end
  end

  // ************************************************************
  // output enable and power good
  // ************************************************************
  // hysteresis keeps power good from chattering near threshold
  wire en_d = seq_d == pmbus_regs_pkg::SEQ_RAMP
    || seq_d == pmbus_regs_pkg::SEQ_ON;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_q <= 1'b0;
      ramp_q <= 1'b0;
      pg_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      ramp_q <= seq_d == pmbus_regs_pkg::SEQ_RAMP; // RULE12
      if (!en_q || vout_sample <= pg_off_q)
        pg_q <= 1'b0; // RULE10
      else if (vout_sample >= pg_on_q)
        pg_q <= 1'b1;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign output_en = en_q;
  assign ramp_active = ramp_q;
  assign power_good = pg_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_read_word;
    rd && h_swd;
  endsequence

  a_oc_warn_cross: assert property ( // RULE1
    oc_warn_q < oc_fault_q && oc_warn_q >= pmbus_regs_pkg::OC_WARN_MIN)
    else $error("warning limit out of range or cross-check");
  a_ot_limit_cross: assert property ( // RULE2
    ot_fault_q > ot_warn_q && ot_fault_q <= pmbus_regs_pkg::OT_FAULT_MAX)
    else $error("overtemp limits crossed");
  a_vin_ov_off: assert property ( // RULE8
    vov_live && en_q |=> !en_q)
    else $error("output stayed on during input overvoltage");
  a_ot_resp_fixed: assert property ( // RULE5
    ot_resp_q[7:6] == 2'h2 && ot_resp_q[2:0] == 3'h0
    && (ot_resp_q[5:3] == 3'h0 || ot_resp_q[5:3] == 3'h7))
    else $error("illegal overtemp response value");
  a_ot_latch_hold: assert property ( // RULE6
    seq_q == pmbus_regs_pkg::SEQ_LATCH && on_cmd |=> !en_q ##0
    seq_q == pmbus_regs_pkg::SEQ_LATCH)
    else $error("latched overtemp shutdown restarted");
  a_pg_gap: assert property ( // RULE10
    {1'b0, pg_on_q} >= {1'b0, pg_off_q} + 17'h00010)
    else $error("power good gap lost");
  a_delay_done: assert property ( // RULE11
    $rose(seq_q == pmbus_regs_pkg::SEQ_RAMP)
    |-> $past(ms_q) == $past(ton_dly_q) - 16'h0001)
    else $error("ramp began before the turn-on delay");
  a_word_unsup: assert property ( // RULE14
    s_read_word |=> rsp_valid && rsp_data[12] == 1'b0
    && rsp_data[10:7] == 4'h0)
    else $error("unsupported summary bit set");
  a_flag_set_wins: assert property ( // RULE18
    ot_live && wr && h_stp |=> st_temp_q[7])
    else $error("overtemp flag lost against clear");
  a_bad_keeps: assert property ( // RULE21
    bad_data && h_ocw |=> $stable(oc_warn_q) && st_cml_q[6])
    else $error("refused write changed a limit");
  a_vin_restart: assert property ( // RULE9
    seq_q == pmbus_regs_pkg::SEQ_OFF && on_cmd && !other_live
    |=> seq_q == pmbus_regs_pkg::SEQ_DELAY)
    else $error("no restart after fault cleared");

endmodule

// ---- pmbus_host_model.sv ----
// ****************************************
// host side of the command port
// ****************************************
module pmbus_host_model (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic cmd_pec_err,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus before the first command
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    cmd_pec_err = 1'b0;
  end

  // one-cycle command pulse; code, data and pec are inverted afterwards so a stale value never helps
  task automatic send(input logic w, input logic [7:0] code, input logic [15:0] data, input logic pec,
                      output logic [15:0] rd);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = code;
    cmd_wdata = data;
    cmd_pec_err = pec;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
    cmd_pec_err = ~pec;
    rd = rsp_valid ? rsp_data : 16'hxxxx;
  endtask
endmodule

// ---- power_module_fault_status_regs_test.sv ----
// ****************************************
// self-checking bench for the fault and status registers
// ****************************************
module power_module_fault_status_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_pec_err, rsp_valid, output_en, ramp_active, power_good;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data;
  logic on_cmd = 1'b0;
  logic vout_ov_fault = 1'b0;
  logic vin_uv_fault = 1'b0;
  logic [15:0] vin_sample = 16'h01e0;
  logic [15:0] vout_sample = 16'h0078;
  logic [15:0] iout_sample = 16'h0000;
  logic [15:0] temp_sample = 16'h001e;
  int errors = 0;
  int n_compared = 0;
  int c;
  // code, data, accepted; short ms counts keep the run small
  localparam logic [24:0] LIM_TAB [16] = '{
    {8'h4a, 16'h0029, 1'b0},
    {8'h4a, 16'h0009, 1'b0},
    {8'h4a, 16'h0028, 1'b1},
    {8'h46, 16'h0028, 1'b0},
    {8'h4f, 16'h008d, 1'b0},
    {8'h4f, 16'h006e, 1'b0},
    {8'h51, 16'h007e, 1'b0},
    {8'h55, 16'h01df, 1'b0},
    {8'h55, 16'h0385, 1'b0},
    {8'h5f, 16'h005f, 1'b0},
    {8'h5f, 16'h005e, 1'b1},
    {8'h60, 16'h01f5, 1'b0},
    {8'h61, 16'h000e, 1'b0},
    {8'h50, 16'h00b9, 1'b0},
    {8'h50, 16'h0090, 1'b0},
    {8'h50, 16'h0080, 1'b1}};

  always #5 ref_clk = ~ref_clk;

  pmbus_fault_regs #(.CYC_PER_MS(4)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_pec_err(cmd_pec_err),
    .on_cmd(on_cmd), .vin_sample(vin_sample), .vout_sample(vout_sample), .iout_sample(iout_sample),
    .temp_sample(temp_sample), .vout_ov_fault(vout_ov_fault), .vin_uv_fault(vin_uv_fault),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .output_en(output_en), .ramp_active(ramp_active),
    .power_good(power_good));

  pmbus_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_pec_err(cmd_pec_err), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input string what, input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] r;
    host.send(1'b0, code, 16'h0000, 1'b0, r);
    chk(what, exp, r);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic pec);
    logic [15:0] r;
    host.send(1'b1, code, data, pec, r);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // fixed reads straight after reset
  task automatic t_reset;
    rdc("ot_resp", 8'h50, 16'h00b8);
    rdc("vin_resp", 8'h56, 16'h00c0);
    rdc("word", 8'h79, 16'h0840);
    $display("test reset done");
  endtask

  // each rejected write must leave the old value and raise bad data
  task automatic t_limits;
    logic [15:0] old;
    foreach (LIM_TAB[i])
    begin
      host.send(1'b0, LIM_TAB[i][24:17], 16'h0000, 1'b0, old);
      wr(LIM_TAB[i][24:17], LIM_TAB[i][16:1], 1'b0);
      rdc("limit", LIM_TAB[i][24:17], LIM_TAB[i][0] ? LIM_TAB[i][16:1] : old);
      rdc("cml", 8'h7e, LIM_TAB[i][0] ? 16'h0000 : 16'h0040);
      wr(8'h7e, 16'h0040, 1'b0);
    end
    wr(8'h56, 16'h0000, 1'b0);
    rdc("vin_resp", 8'h56, 16'h00c0);
    rdc("unknown", 8'h47, 16'hxxxx);
    wr(8'h7e, 16'h0000, 1'b1);
    rdc("cml", 8'h7e, 16'h00a0);
    wr(8'h7e, 16'h00e0, 1'b0);
    rdc("cml", 8'h7e, 16'h0000);
    $display("test limits done");
  endtask

  // sticky flags, summary word and clear by writing ones
  task automatic t_flags;
    logic [15:0] exp [4] = '{16'h0080, 16'h00a0, 16'h0010, 16'h0040};
    @(posedge ref_clk);
    #1;
    {iout_sample, temp_sample, vout_ov_fault, vin_uv_fault} = {16'h002e, 16'h0070, 2'b11};
    repeat (2) @(posedge ref_clk);
    #1;
    {iout_sample, temp_sample, vout_ov_fault, vin_uv_fault} = {16'h0000, 16'h001e, 2'b00};
    rdc("word", 8'h79, 16'he87c);
    foreach (exp[i])
      rdc("status", 8'h7a + 8'(i), exp[i]);
    foreach (exp[i])
      wr(8'h7a + 8'(i), 16'h00ff, 1'b0);
    foreach (exp[i])
      rdc("cleared", 8'h7a + 8'(i), 16'h0000);
    rdc("word", 8'h79, 16'h0840);
    $display("test flags done");
  endtask

  // delay, ramp, input overvoltage shutdown and restart
  task automatic t_seq;
    @(posedge ref_clk);
    #1;
    on_cmd = 1'b1;
    // look just after each edge so the flop has settled
    for (c = 0; c < 200 && output_en !== 1'b1; c++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("delay ok", 16'h0001, 16'((c >= 40) && (c <= 43)));
    for (c = 0; c < 200 && ramp_active === 1'b1; c++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("ramp ok", 16'h0001, 16'((c >= 58) && (c <= 61)));
    repeat (3) @(posedge ref_clk);
    #1;
    chk("pgood", 16'h0001, 16'(power_good));
    vin_sample = 16'h0321;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("vin_ov off", 16'h0000, 16'(output_en));
    rdc("input", 8'h7c, 16'h0080);
    rdc("word", 8'h79, 16'h2840);
    vin_sample = 16'h01e0;
    for (c = 0; c < 200 && output_en !== 1'b1; c++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("restart ok", 16'h0001, 16'((c >= 36) && (c <= 43)));
    // retry never is loaded by now: overtemp must latch the output off
    temp_sample = 16'h007e;
    repeat (50) @(posedge ref_clk);
    #1;
    chk("ot latched", 16'h0000, 16'(output_en));
    wr(8'h7d, 16'h00ff, 1'b0);
    rdc("temp", 8'h7d, 16'h00c0);
    temp_sample = 16'h001e;
    repeat (50) @(posedge ref_clk);
    #1;
    chk("ot stays off", 16'h0000, 16'(output_en));
    on_cmd = 1'b0;
    $display("test sequence done");
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // tests need under 2000 cycles; a stall is cut off well beyond that
  initial
  begin
    #200000;
    errors++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_limits();
    t_flags();
    t_seq();
    final_report();
  end
endmodule
